// ==== src/frpc_pkg.sv ====
/*
  Constants and types shared by the reset and power-on control of a serial
  flash device.
  Assumes a 25 MHz device clock; all cycle counts derive from it.
*/
package frpc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ              = 25;
  localparam int unsigned RESET_PULSE_WIDTH_US = 10;
  localparam int unsigned RESET_HIGH_TO_SEL_US = 10;
  localparam int unsigned POWERON_RECOVERY_US  = 35;
  localparam int unsigned DECODE_RECOVERY_US   = 40;
  localparam int unsigned READ_RECOVERY_US     = 35;
  localparam int unsigned PROG_RECOVERY_US     = 310;
  localparam int unsigned SE4K_RECOVERY_MS     = 12;
  localparam int unsigned BLOCK_RECOVERY_MS    = 25;
  localparam int unsigned CHIP_RECOVERY_MS     = 100;
  localparam int unsigned STATUS_RECOVERY_MS   = 40;
  localparam int unsigned SUPPLY_STABLE_US     = 100;

  // Least times round up; these divide exactly at 25 MHz.
  localparam int unsigned RESET_PULSE_CYC   = RESET_PULSE_WIDTH_US * CLK_MHZ;
  localparam int unsigned RESET_HIGH_CYC    = RESET_HIGH_TO_SEL_US * CLK_MHZ;
  localparam int unsigned POWERON_REC_CYC   = POWERON_RECOVERY_US * CLK_MHZ;
  localparam int unsigned DECODE_REC_CYC    = DECODE_RECOVERY_US * CLK_MHZ;
  localparam int unsigned READ_REC_CYC      = READ_RECOVERY_US * CLK_MHZ;
  localparam int unsigned PROG_REC_CYC      = PROG_RECOVERY_US * CLK_MHZ;
  localparam int unsigned SE4K_REC_CYC      = SE4K_RECOVERY_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLOCK_REC_CYC     = BLOCK_RECOVERY_MS * 1000 * CLK_MHZ;
  localparam int unsigned CHIP_REC_CYC      = CHIP_RECOVERY_MS * 1000 * CLK_MHZ;
  localparam int unsigned STATUS_REC_CYC    = STATUS_RECOVERY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SUPPLY_STABLE_CYC = SUPPLY_STABLE_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Widths, opcodes and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W   = 24;
  localparam int unsigned PULSE_W = 9;
  localparam int unsigned SYNC_W  = 6;
  localparam logic [7:0]  OPC_RESET_ENABLE = 8'h66;
  localparam logic [7:0]  OPC_RESET        = 8'h99;
  localparam logic [3:0]  OPC_BITS         = 4'h8;
  localparam logic        WEL_RST   = 1'h0;
  localparam logic        WIP_RST   = 1'h0;
  localparam logic        ADDR4_RST = 1'h0;
  localparam logic        LOCK_RST  = 1'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE, OP_READ, OP_PROG, OP_SE4K, OP_BLOCK, OP_CHIP, OP_STATUS
  } frpc_op_t;

  typedef enum logic [2:0] {
    ST_POR, ST_STABLE, ST_RESET, ST_RECOVER, ST_READY
  } frpc_state_t;

endpackage

// ==== src/frpc_sync.sv ====
/*
  Two-flop synchroniser for the pins that enter the device clock domain.
  Assumes its inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/1ps
module frpc_sync
  import frpc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [SYNC_W-1:0] rst_val,
  input  wire logic [SYNC_W-1:0] din,
  output logic      [SYNC_W-1:0] dout
);

  logic [SYNC_W-1:0] meta_ff;

  // ----------------------------------------------------------------------
  // Both stages
  // ----------------------------------------------------------------------
  // Reset value is the constant zero here; rst_val at the instance is not used.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= SYNC_W'(0);
      dout    <= SYNC_W'(0);
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

  // Both stages reset to zero; callers invert idle-high pins so that zero
  // is their idle level. rst_val stays a tie-off for such callers.
  logic unused_ok;
  assign unused_ok = ^rst_val;

endmodule

// ==== src/frpc_top.sv ====
/*
  Reset and power-on control of a serial flash device: hardware reset pin,
  software reset pair, power-on gating and post-reset recovery.
  Assumes the flash core reports its running operation on op_kind/op_busy
  and obeys core_reset_ff; host pins are asynchronous to clock.
*/
// Behaviour
// - Reset pin low at least 10 us resets the device.
// - After reset: standby, volatile bits at defaults, 3-byte addressing.
// - Reset during program or erase aborts it at once.
// - While reset pin low, data output is high impedance, activity minimal.
// - Software reset only when reset-enable 66h precedes reset 99h.
// - Power-up enters standby, not deep power-down, latch cleared.
// - Below write-inhibit threshold, logic held in reset, commands ignored.
// - Commands rejected until supply stable delay after supply minimum.
`timescale 1ns/1ps
module frpc_top
  import frpc_pkg::*;
#(
  parameter int unsigned PROG_REC   = PROG_REC_CYC,
  parameter int unsigned SE4K_REC   = SE4K_REC_CYC,
  parameter int unsigned BLOCK_REC  = BLOCK_REC_CYC,
  parameter int unsigned CHIP_REC   = CHIP_REC_CYC,
  parameter int unsigned STATUS_REC = STATUS_REC_CYC
)(
  input  wire logic     clock,
  input  wire logic     rstn,
  input  wire logic     reset_pin_n,
  input  wire logic     cs_n,
  input  wire logic     sclk,
  input  wire logic     si,
  input  wire logic     below_inhibit,
  input  wire logic     supply_min_ok,
  input  wire frpc_op_t op_kind,
  input  wire logic     op_busy,
  input  wire logic     so_drive_req,
  input  wire logic     wel_set,
  input  wire logic     wel_clr,
  input  wire logic     addr4_set,
  input  wire logic     addr4_clr,
  input  wire logic     lock_set,
  input  wire logic     lock_clr,
  output logic          core_reset_ff,
  output logic          cmd_ready_ff,
  output logic          abort_op_ff,
  output logic          so_oe_ff,
  output logic          write_enable_latch_ff,
  output logic          write_in_progress_ff,
  output logic          addr4_ff,
  output logic          vol_lock_ff
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  frpc_sync u_sync (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (SYNC_W'(0)),
    .din     ({~reset_pin_n, ~cs_n, sclk, si, ~below_inhibit, supply_min_ok}),
    .dout    (pins_s)
  );

  // Idle-high pins cross inverted, so the zero reset of the synchroniser
  // reads as idle pins and a low supply: no false edge follows reset.
  wire pin_n_s  = ~pins_s[5];
  wire cs_n_s   = ~pins_s[4];
  wire sclk_s   = pins_s[3];
  wire si_s     = pins_s[2];
  wire por_s    = ~pins_s[1];
  wire supply_s = pins_s[0];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  frpc_state_t        state_ff, nxt_state;
  logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
  logic [PULSE_W-1:0] pulse_ff;
  logic               pin_d_ff, sclk_d_ff, cs_d_ff;
  logic [7:0]         shift_ff;
  logic [3:0]         bits_ff;
  logic               armed_ff;
  logic [CNT_W-1:0]   rec_ff;

  // Recovery length for whatever the reset interrupted.
  function automatic logic [CNT_W-1:0] rec_sel(input frpc_op_t k,
                                               input logic sel,
                                               input logic ready);
    logic [CNT_W-1:0] r;
    r = CNT_W'(POWERON_REC_CYC);
    if (ready) begin
      unique case (k)
        OP_IDLE:   r = sel ? CNT_W'(DECODE_REC_CYC) : CNT_W'(READ_REC_CYC);
        OP_READ:   r = CNT_W'(READ_REC_CYC);
        OP_PROG:   r = CNT_W'(PROG_REC);
        OP_SE4K:   r = CNT_W'(SE4K_REC);
        OP_BLOCK:  r = CNT_W'(BLOCK_REC);
        OP_CHIP:   r = CNT_W'(CHIP_REC);
        OP_STATUS: r = CNT_W'(STATUS_REC);
        default:   r = CNT_W'(POWERON_REC_CYC);
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Decode of pin events and the command byte
  // ----------------------------------------------------------------------
  wire ready    = (state_ff == ST_READY);
  // A pin reset before power-up ends must not skip the supply delay.
  wire powered  = (state_ff != ST_POR) && (state_ff != ST_STABLE);
  wire pin_fall = pin_d_ff & ~pin_n_s;
  wire sclk_up  = ~sclk_d_ff & sclk_s & ~cs_n_s;
  wire cs_rise  = ~cs_d_ff & cs_n_s;
  // A short glitch never qualifies; only a full-width pulse resets.
  wire hw_hit   = ~pin_n_s & (pulse_ff == PULSE_W'(RESET_PULSE_CYC - 1));
  wire byte_end = cs_rise & (bits_ff == OPC_BITS) & ready;
  wire sw_hit   = byte_end & armed_ff & (shift_ff == OPC_RESET);
  wire cnt_zero = (cnt_ff == CNT_W'(0));

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_zero ? cnt_ff : cnt_ff - CNT_W'(1);
    if (por_s) begin
      nxt_state = ST_POR;
    end else if (hw_hit && powered) begin
      nxt_state = ST_RESET;
    end else begin
      unique case (state_ff)
        ST_POR: begin
          if (supply_s) begin
            nxt_state = ST_STABLE;
            nxt_cnt   = CNT_W'(SUPPLY_STABLE_CYC);
          end
        end
        ST_STABLE: begin
          if (!supply_s) begin
            nxt_state = ST_POR;
          end else if (cnt_zero) begin
            nxt_state = ST_READY;
          end
        end
        ST_RESET: begin
          if (pin_n_s) begin
            nxt_state = ST_RECOVER;
            nxt_cnt   = rec_ff;
          end
        end
        ST_RECOVER: begin
          if (cnt_zero) begin
            nxt_state = ST_READY;
          end
        end
        ST_READY: begin
          if (sw_hit) begin
            nxt_state = ST_RECOVER;
            nxt_cnt   = rec_sel(op_kind, 1'b1, 1'b1);
          end
        end
      endcase
    end
  end

  // State and count; the core sits in reset outside ready.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff      <= ST_POR;
      cnt_ff        <= CNT_W'(0);
      core_reset_ff <= 1'b1;
      cmd_ready_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      core_reset_ff <= (nxt_state != ST_READY);
      cmd_ready_ff  <= (nxt_state == ST_READY);
    end
  end

  // ----------------------------------------------------------------------
  // Reset pin width and what it interrupted
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_d_ff    <= 1'b1;
      pulse_ff    <= PULSE_W'(0);
      rec_ff      <= CNT_W'(POWERON_REC_CYC);
      abort_op_ff <= 1'b0;
    end else begin
      pin_d_ff    <= pin_n_s;
      if (pin_n_s) begin
        pulse_ff <= PULSE_W'(0);
      end else if (!hw_hit) begin
        pulse_ff <= pulse_ff + PULSE_W'(1);
      end
      if (pin_fall) begin
        rec_ff <= rec_sel(op_kind, ~cs_n_s, ready);
      end
      abort_op_ff <= pin_fall & op_busy;
    end
  end

  // ----------------------------------------------------------------------
  // Command byte capture for the software reset pair
  // ----------------------------------------------------------------------
  // The pin clock runs far slower than clock, so edge sampling is safe.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
      shift_ff  <= 8'h00;
      bits_ff   <= 4'h0;
      armed_ff  <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_n_s;
      if (cs_n_s) begin
        bits_ff <= 4'h0;
      end else if (sclk_up) begin
        shift_ff <= {shift_ff[6:0], si_s};
        bits_ff  <= (bits_ff == 4'hF) ? bits_ff : bits_ff + 4'h1;
      end
      // Any other completed command breaks the pair.
      if (!ready) begin
        armed_ff <= 1'b0;
      end else if (byte_end) begin
        armed_ff <= (shift_ff == OPC_RESET_ENABLE);
      end else if (cs_rise) begin
        armed_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Volatile state and output enable
  // ----------------------------------------------------------------------
  // Outside ready every volatile bit is forced to its power-on value.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      write_enable_latch_ff <= WEL_RST;
      write_in_progress_ff  <= WIP_RST;
      addr4_ff              <= ADDR4_RST;
      vol_lock_ff           <= LOCK_RST;
      so_oe_ff              <= 1'b0;
    end else if (nxt_state != ST_READY) begin
      write_enable_latch_ff <= WEL_RST;
      write_in_progress_ff  <= WIP_RST;
      addr4_ff              <= ADDR4_RST;
      vol_lock_ff           <= LOCK_RST;
      so_oe_ff              <= 1'b0;
    end else begin
      write_enable_latch_ff <= wel_set | (write_enable_latch_ff & ~wel_clr);
      write_in_progress_ff  <= op_busy;
      addr4_ff              <= addr4_set | (addr4_ff & ~addr4_clr);
      vol_lock_ff           <= lock_set | (vol_lock_ff & ~lock_clr);
      so_oe_ff              <= so_drive_req & pin_n_s;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_pin_low_full;
    !pin_n_s && pulse_ff == PULSE_W'(RESET_PULSE_CYC - 1);
  endsequence
  sequence s_defaults;
    !write_enable_latch_ff && !write_in_progress_ff && !addr4_ff;
  endsequence

  property p_pulse_width;
    hw_hit && !por_s && powered |=> state_ff == ST_RESET ##1 core_reset_ff;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("full reset pulse did not reset");

  property p_short_ignored;
    ready && !pin_n_s && pulse_ff < PULSE_W'(RESET_PULSE_CYC - 1) && !por_s
      && !sw_hit |=> state_ff == ST_READY;
  endproperty
  a_short_ignored: assert property (p_short_ignored)
    else $error("short reset pulse acted");

  property p_defaults;
    s_pin_low_full |=> ##1 s_defaults and vol_lock_ff;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("volatile bits not at defaults");

  property p_abort;
    pin_d_ff && !pin_n_s && op_busy |=> abort_op_ff;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort missing");

  property p_so_hiz;
    !pin_n_s |=> !so_oe_ff;
  endproperty
  a_so_hiz: assert property (p_so_hiz)
    else $error("output driven during reset");

  property p_sw_pair;
    $rose(state_ff == ST_RECOVER) && $past(ready) && !$past(hw_hit)
      |-> $past(armed_ff) && $past(shift_ff) == OPC_RESET;
  endproperty
  a_sw_pair: assert property (p_sw_pair)
    else $error("software reset without enable");

  property p_powerup;
    state_ff == ST_POR |-> !cmd_ready_ff ##1 !write_enable_latch_ff;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("power-up state wrong");

  property p_por_hold;
    por_s |=> core_reset_ff && !cmd_ready_ff [*2];
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("commands live below threshold");

  property p_stable_delay;
    $rose(state_ff == ST_STABLE) |->
      cnt_ff == CNT_W'(SUPPLY_STABLE_CYC) ##1 !cmd_ready_ff [*8];
  endproperty
  a_stable_delay: assert property (p_stable_delay)
    else $error("ready before supply stable delay");

  property p_count_done;
    $rose(cmd_ready_ff) |-> $past(cnt_zero, 2) || $past(cnt_zero);
  endproperty
  a_count_done: assert property (p_count_done)
    else $error("ready before counter expired");

endmodule

// ==== sim/frpc_host_model.sv ====
/*
  Behavioural host flash controller: drives reset pin, select, link clock
  and serial data of the reset and power-on control.
  Assumes the device clock runs free; the link clock moves only in frames.
*/
`timescale 1ns/1ps
module frpc_host_model
  import frpc_pkg::*;
(
  input  wire logic clock,
  output logic      reset_pin_n,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  int unsigned since_rel = 0;

  // Reset pin idle high and deselected at time zero; link clock and data low.
  initial begin
    reset_pin_n = 1'h1;
    cs_n        = 1'h1;
    sclk        = 1'h0;
    si          = 1'h0;
  end

  // Cycles since the reset pin went high; selection waits on this count.
  always @(posedge clock) begin
    if (!reset_pin_n) since_rel <= 0;
    else if (since_rel < RESET_HIGH_CYC) since_rel <= since_rel + 1;
  end

  // Reset pin low for low_cyc device clocks; callers that want a real
  // reset pass at least the pulse width.
  task automatic hw_reset(input int unsigned low_cyc);
    @(posedge clock) #2 reset_pin_n = 1'h0;
    repeat (low_cyc) @(posedge clock);
    #2 reset_pin_n = 1'h1;
  endtask

  // One whole opcode, MSB first, 160 ns per link half period.
  task automatic send_op(input logic [7:0] opc);
    while (since_rel < RESET_HIGH_CYC) @(posedge clock);
    @(posedge clock) #2 cs_n = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      si = opc[i];
      repeat (4) @(posedge clock);
      #2 sclk = 1'h1;
      repeat (4) @(posedge clock);
      #2 sclk = 1'h0;
    end
    repeat (4) @(posedge clock);
    #2 cs_n = 1'h1;
    // A released line must not keep showing the last bit.
    si = ~si;
  endtask
endmodule

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the reset and power-on control.
  Assumes the host model drives the pins; the core side is driven here.
*/
`timescale 1ns/1ps
module tb_top
  import frpc_pkg::*;
;
  // ----------------------------------------------------------------------
  // Set-up
  // ----------------------------------------------------------------------
  // Short recovery counts keep the run short; a long count adds nothing.
  localparam int unsigned PROG_T  = 120;
  localparam int unsigned SE4K_T  = 140;
  localparam int unsigned BLOCK_T = 160;
  localparam int unsigned CHIP_T  = 180;
  localparam int unsigned STAT_T  = 200;
  localparam int unsigned SLACK   = 16;

  logic        clock = 1'h0;
  logic        rstn, below_inhibit, supply_min_ok, op_busy, so_drive_req;
  logic        wel_set, wel_clr, addr4_set, addr4_clr, lock_set, lock_clr;
  frpc_op_t    op_kind;
  wire         reset_pin_n, cs_n, sclk, si;
  wire         core_reset_ff, cmd_ready_ff, abort_op_ff, so_oe_ff;
  wire         write_enable_latch_ff, write_in_progress_ff;
  wire         addr4_ff, vol_lock_ff;
  int          mismatches = 0;
  int          compares = 0;
  logic [31:0] rng = 32'hDF6C;

  always #20 clock = ~clock;

  frpc_top #(
    .PROG_REC(PROG_T), .SE4K_REC(SE4K_T), .BLOCK_REC(BLOCK_T),
    .CHIP_REC(CHIP_T), .STATUS_REC(STAT_T)
  ) frpc_top_inst (
    .clock, .rstn, .reset_pin_n, .cs_n, .sclk, .si, .below_inhibit,
    .supply_min_ok, .op_kind, .op_busy, .so_drive_req, .wel_set, .wel_clr,
    .addr4_set, .addr4_clr, .lock_set, .lock_clr, .core_reset_ff,
    .cmd_ready_ff, .abort_op_ff, .so_oe_ff, .write_enable_latch_ff,
    .write_in_progress_ff, .addr4_ff, .vol_lock_ff
  );

  frpc_host_model frpc_host_model_inst (
    .clock, .reset_pin_n, .cs_n, .sclk, .si
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Repeatable pseudo-random source.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Expected recovery after a hardware reset; idle with select high counts
  // as a read.
  function automatic int unsigned rec_cyc(input frpc_op_t op);
    case (op)
      OP_PROG:   return PROG_T;
      OP_SE4K:   return SE4K_T;
      OP_BLOCK:  return BLOCK_T;
      OP_CHIP:   return CHIP_T;
      OP_STATUS: return STAT_T;
      default:   return READ_REC_CYC;
    endcase
  endfunction

  // A count is good when it is the least time plus pipeline slack.
  function automatic logic in_win(input int n, input int unsigned lo);
    return (n >= lo) && (n <= lo + SLACK);
  endfunction

  // Inputs move 2 ns after the edge, outputs are read there too.
  task automatic step();
    @(posedge clock);
    #2;
  endtask

  task automatic check(input logic seen, input logic exp, input string msg);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Commands are only ever sent after this returns.
  task automatic wait_ready(output int n);
    n = 0;
    while (cmd_ready_ff !== 1'h1) begin
      step();
      n++;
      if (n > 4000) begin
        check(1'h0, 1'h1, "ready timeout");
        test_done();
      end
    end
  endtask

  task automatic check_dflt();
    check(write_enable_latch_ff, WEL_RST, "latch default");
    check(write_in_progress_ff, WIP_RST, "busy default");
    check(addr4_ff, ADDR4_RST, "3-byte default");
    check(vol_lock_ff, LOCK_RST, "lock default");
  endtask

  // One-cycle pulses from the core move the volatile bits away from reset when v is 1, back to it when v is 0.
  task automatic set_bits(input logic v);
    step();
    {wel_set, addr4_set, lock_clr} = {3{v}};
    {wel_clr, addr4_clr, lock_set} = {3{~v}};
    step();
    {wel_set, wel_clr, addr4_set, addr4_clr, lock_set, lock_clr} = 6'h00;
    repeat (3) step();
    check(write_enable_latch_ff, v, "latch update");
    check(addr4_ff, v, "address mode update");
    check(vol_lock_ff, ~v, "lock update");
  endtask

  task automatic power_up();
    int n;
    wait_ready(n);
    check(in_win(n, SUPPLY_STABLE_CYC), 1'h1, "stable delay");
    check(core_reset_ff, 1'h0, "core released");
  endtask

  // Three whole opcodes, then whether a software reset followed.
  task automatic sw_seq(input logic [7:0] a, b, c, input logic exp);
    logic seen;
    int   n;
    frpc_host_model_inst.send_op(a);
    frpc_host_model_inst.send_op(b);
    frpc_host_model_inst.send_op(c);
    seen = 1'h0;
    repeat (12) begin
      step();
      seen |= core_reset_ff;
    end
    check(seen, exp, "software reset");
    if (exp) begin
      check_dflt();
      wait_ready(n);
      check(in_win(n + 12, DECODE_REC_CYC), 1'h1, "decode wait");
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int          n;
    int unsigned len;
    frpc_op_t    op;
    logic        ab;
    logic [7:0]  junk;
    rstn          = 1'h0;
    below_inhibit = 1'h1;
    supply_min_ok = 1'h0;
    op_kind       = OP_IDLE;
    op_busy       = 1'h0;
    so_drive_req  = 1'h0;
    {wel_set, wel_clr, addr4_set, addr4_clr, lock_set, lock_clr} = 6'h00;
    repeat (16) @(posedge clock);
    #2 rstn = 1'h1;
    check_dflt();
    repeat (60) step();
    check(core_reset_ff, 1'h1, "held while inhibited");
    check(cmd_ready_ff, 1'h0, "ready while inhibited");
    below_inhibit = 1'h0;
    supply_min_ok = 1'h1;
    power_up();
    // Hardware reset against every operation kind, busy or not.
    for (int i = 0; i < 7; i++) begin
      op = frpc_op_t'(i);
      set_bits(1'h1);
      op_kind = op;
      op_busy = (op >= OP_PROG);
      so_drive_req = 1'h1;
      step();
      check(write_in_progress_ff, op_busy, "busy follows core");
      check(so_oe_ff, 1'h1, "output driven when asked");
      rng = xs(rng);
      len = RESET_PULSE_CYC + 20 + rng[3:0];
      fork
        frpc_host_model_inst.hw_reset(len);
        begin
          ab = 1'h0;
          repeat (10) begin
            step();
            ab |= abort_op_ff;
          end
          check(ab, op_busy, "abort on reset");
          check(so_oe_ff, 1'h0, "output released");
          repeat (255) step();
          check(core_reset_ff, 1'h1, "core held");
          check(cmd_ready_ff, 1'h0, "commands refused");
          check_dflt();
        end
      join
      op_busy = 1'h0;
      so_drive_req = 1'h0;
      wait_ready(n);
      check(in_win(n, rec_cyc(op)), 1'h1, "recovery");
      op_kind = OP_IDLE;
    end
    // A pulse below the width resets nothing.
    set_bits(1'h1);
    rng = xs(rng);
    frpc_host_model_inst.hw_reset(20 + rng[6:0]);
    repeat (10) step();
    check(core_reset_ff, 1'h0, "short pulse");
    check(write_enable_latch_ff, 1'h1, "latch kept");
    // Software reset pair, with a stray opcode before and between.
    rng = xs(rng);
    junk = rng[7:0];
    if (junk == OPC_RESET_ENABLE || junk == OPC_RESET) junk = 8'h5A;
    sw_seq(junk, OPC_RESET_ENABLE, OPC_RESET, 1'h1);
    set_bits(1'h1);
    sw_seq(OPC_RESET_ENABLE, junk, OPC_RESET, 1'h0);
    // Supply dip in mid-run.
    below_inhibit = 1'h1;
    repeat (4) step();
    check(core_reset_ff, 1'h1, "dip resets");
    check(cmd_ready_ff, 1'h0, "dip refuses");
    check_dflt();
    below_inhibit = 1'h0;
    power_up();
    set_bits(1'h0);
    test_done();
  end
endmodule
